/* File: testbench/timer01_mode0_counter_bench.sv */
// timer01_mode0_counter_bench: apb sequences against tmc_top.
// assumes tmc_pin_model drives the pins and the checker is bound.
`timescale 1ns/10ps
module timer01_mode0_counter_bench;
  import tmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        c0, c1, g0, g1;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [12:0] v;
  int          fail_count, checks, cyc;

  tmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_0(c0), .count_input_1(c1),
    .external_gate_input_0(g0), .external_gate_input_1(g1), .irq(irq));
  tmc_pin_model pin (.pclk(pclk), .cnt0(c0), .cnt1(c1), .gate_enable_0(g0), .gate1(g1));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && cyc < 20000);
    rdat = prdata;
    err  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cnt13(input logic [7:0] hi, input logic [7:0] lo);
    acc(1'b0, hi, 0);
    v[12:5] = rdat[7:0];
    acc(1'b0, lo, 0);
    v[4:0] = rdat[4:0];
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, 8'(i * 4), 0);
      chk("reset value", 0, rdat);
    end
    acc(1'b0, 8'h20, 0);
    chk("unmapped error", 1, err);
    $display("test reset done");
    acc(1'b1, TMC_OFS_MODE, 32'h04);
    acc(1'b1, TMC_OFS_T0_LOW, 32'h1F);
    acc(1'b1, TMC_OFS_T0_HIGH, 32'hFF);
    acc(1'b1, TMC_OFS_CONTROL, 32'h10);
    pin.pulse(0, 1);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("t0 wrap count", 0, v);
    acc(1'b0, TMC_OFS_CONTROL, 0);
    chk("t0 overflow flag", 32'h30, rdat);
    chk("irq masked", 0, irq);
    acc(1'b1, TMC_OFS_IRQ_MASK, 32'h01);
    chk("irq unmasked", 1, irq);
    acc(1'b1, TMC_OFS_CONTROL, 32'h30);
    acc(1'b0, TMC_OFS_CONTROL, 0);
    chk("flag cleared", 32'h10, rdat);
    chk("irq cleared", 0, irq);
    pin.pulse(0, 5);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("t0 pin count", 5, v);
    $display("test counter done");
    acc(1'b1, TMC_OFS_MODE, 32'h0C);
    pin.gate(0, 1'b0);
    pin.pulse(0, 3);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("gated off", 5, v);
    pin.gate(0, 1'b1);
    pin.pulse(0, 3);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("gated on", 8, v);
    acc(1'b1, TMC_OFS_T1_LOW, 32'h13);
    acc(1'b1, TMC_OFS_MODE, 32'h4C);
    acc(1'b1, TMC_OFS_CONTROL, 32'h50);
    cnt13(TMC_OFS_T1_HIGH, TMC_OFS_T1_LOW);
    chk("run keeps count", 32'h13, v);
    pin.pulse(1, 4);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T1_HIGH, TMC_OFS_T1_LOW);
    chk("t1 pin count", 32'h17, v);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("t0 untouched", 8, v);
    $display("test gate and timer1 done");
    acc(1'b1, TMC_OFS_CONTROL, 0);
    acc(1'b1, TMC_OFS_MODE, 0);
    for (int i = 0; i < 4; i++)
      acc(1'b1, 8'(i * 4), 0);
    acc(1'b1, TMC_OFS_CLKCTL, 32'h08);
    acc(1'b1, TMC_OFS_CONTROL, 32'h50);
    repeat (120) @(posedge pclk);
    acc(1'b1, TMC_OFS_CONTROL, 0);
    // run spans 124 edges; the free-running divider phase gives 10 or 11 slow ticks
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("div1 ticks", 124, v);
    cnt13(TMC_OFS_T1_HIGH, TMC_OFS_T1_LOW);
    chk("div12 ticks", 1, v >= 10 && v <= 11);
    $display("test ticks done");
    acc(1'b1, TMC_OFS_T1_LOW, 32'h1F);
    acc(1'b1, TMC_OFS_T1_HIGH, 32'hFF);
    acc(1'b1, TMC_OFS_MODE, 32'h45);
    acc(1'b1, TMC_OFS_CONTROL, 32'h50);
    pin.pulse(0, 2);
    pin.pulse(1, 1);
    repeat (6) @(posedge pclk);
    cnt13(TMC_OFS_T0_HIGH, TMC_OFS_T0_LOW);
    chk("t0 mode 1 frozen", 124, v);
    cnt13(TMC_OFS_T1_HIGH, TMC_OFS_T1_LOW);
    chk("t1 wrap count", 0, v);
    acc(1'b0, TMC_OFS_CONTROL, 0);
    chk("t1 overflow flag", 32'hD0, rdat);
    chk("irq t1 masked", 0, irq);
    acc(1'b1, TMC_OFS_IRQ_MASK, 32'h02);
    chk("irq t1 unmasked", 1, irq);
    acc(1'b1, TMC_OFS_IRQ_MASK, 32'h00);
    chk("irq all masked", 0, irq);
    $display("test timer1 overflow done");
    end_sim();
  end
endmodule

/* File: testbench/tmc_pin_model.sv */
// tmc_pin_model: drives the count and gate pins of both timers.
// assumes the bench calls its tasks right after a pclk edge.
`timescale 1ns/10ps
module tmc_pin_model
(
  input wire logic pclk,
  output logic     cnt0,
  output logic     cnt1,
  output logic     gate_enable_0,
  output logic     gate1
);
  logic [1:0] cnt_q;
  logic [1:0] gate_q;
  assign cnt0  = cnt_q[0];
  assign cnt1  = cnt_q[1];
  assign gate_enable_0 = gate_q[0];
  assign gate1 = gate_q[1];
  initial
  begin
    cnt_q  = 2'h3;
    gate_q = 2'h3;
  end
  // each level held two clocks: the fastest rate the timers must follow
  task automatic pulse(input int t, input int n);
    repeat (n)
    begin
      repeat (2) @(posedge pclk);
      cnt_q[t] <= 1'b0;
      repeat (2) @(posedge pclk);
      cnt_q[t] <= 1'b1;
    end
  endtask
  task automatic gate(input int t, input logic v);
    @(posedge pclk);
    gate_q[t] <= v;
  endtask
endmodule

/* File: testbench/tmc_top_asserts.sv */
// tmc_top_asserts: apb and interrupt relations at the tmc_top ports.
// assumes the single pclk domain and the one-wait-state apb slave.
`timescale 1ns/10ps
module tmc_top_asserts
  import tmc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // access phase sequences
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence mask_off_s;
    acc_s ##0 (pwrite && paddr == TMC_OFS_IRQ_MASK && pwdata[1:0] == 2'h0);
  endsequence

  ready_wait_a: assert property (acc_s |=> pready) else $error("no ready after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held two cycles");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data off");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (acc_s ##0 (paddr > TMC_OFS_IRQ_MASK) |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_s ##0 (paddr <= TMC_OFS_IRQ_MASK && paddr[1:0] == 2'h0)
    |=> !pslverr) else $error("mapped access refused");
  rdata_byte_a: assert property (acc_s ##0 !pwrite |=> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  irq_masked_a: assert property (mask_off_s |=> ##1 !irq)
    else $error("irq high with all masked");
endmodule

bind tmc_top tmc_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

/* File: verilog/tmc_cnt_if.sv */
// tmc_cnt_if: bundle between the register file and one timer core.
// assumes a single pclk domain on both sides.
`timescale 1ns/10ps
interface tmc_cnt_if;
  logic       run;
  logic       gate_en;
  logic       ext_sel;
  logic       div1;
  logic [1:0] mode;
  logic       wr_low;
  logic       wr_high;
  logic [7:0] wdata;
  logic [7:0] low_byte;
  logic [7:0] high_byte;
  logic       ovf;

  modport ctl
  (
    output run, gate_en, ext_sel, div1, mode, wr_low, wr_high, wdata,
    input  low_byte, high_byte, ovf
  );
  modport core
  (
    input  run, gate_en, ext_sel, div1, mode, wr_low, wr_high, wdata,
    output low_byte, high_byte, ovf
  );
endinterface

/* File: verilog/tmc_core.sv */
// tmc_core: one counter/timer in mode 0 (13-bit count).
// assumes pin inputs already synchronised and a shared divide-by-twelve
// tick enable on the same pclk.
`timescale 1ns/10ps
module tmc_core
  import tmc_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  tick12,
  input  wire logic  cnt_pin_s,
  input  wire logic  gate_pin_s,
  tmc_cnt_if.core    cif
);

  typedef struct packed
  {
    logic [7:0] low;
    logic [7:0] high;
    logic       pin_prev;
    logic       ovf;
  } tmc_core_s;

  tmc_core_s s_q;
  tmc_core_s s_d;
  logic      enabled;
  logic      inc;
  logic [12:0] cnt13;

  always_comb
  begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    s_d.pin_prev = cnt_pin_s;
    enabled = cif.run && (!cif.gate_en || gate_pin_s);       // [RL12]
    // falling edge from consecutive synchronised samples
    if (cif.ext_sel)                                          // [RL11]
      inc = enabled && s_q.pin_prev && !cnt_pin_s;            // [RL3] [RL15] [RL4]
    else
      inc = enabled && (cif.div1 || tick12);                  // [RL1] [RL2]
    cnt13 = {s_q.high, s_q.low[4:0]};                         // [RL8]
    // only mode 0 is built; other codes leave the count frozen
    if (inc && tmc_mode_e'(cif.mode) == TMC_MODE_13BIT)       // [RL7]
    begin
      cnt13 = 13'(cnt13 + 13'h1);
      s_d.high = cnt13[12:5];
      s_d.low = {s_q.low[7:5], cnt13[4:0]};
      s_d.ovf = (cnt13 == 13'h0000);                          // [RL10]
    end
    // software load wins over an increment; run bit never clears the count
    if (cif.wr_low)                                           // [RL16] [RL14]
      s_d.low = cif.wdata;
    if (cif.wr_high)                                          // [RL16]
      s_d.high = cif.wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cif.low_byte  = s_q.low;
  assign cif.high_byte = s_q.high;
  assign cif.ovf       = s_q.ovf;

endmodule

/* File: verilog/tmc_pkg.sv */
// tmc_pkg: register map, field positions, reset values and timing counts
// of the two mode-0 counter/timers.
// assumes a 32-bit apb slave with one aligned word per register.
package tmc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_OFS_T0_LOW   = 8'h00;
  localparam logic [7:0] TMC_OFS_T0_HIGH  = 8'h04;
  localparam logic [7:0] TMC_OFS_T1_LOW   = 8'h08;
  localparam logic [7:0] TMC_OFS_T1_HIGH  = 8'h0C;
  localparam logic [7:0] TMC_OFS_CONTROL  = 8'h10;
  localparam logic [7:0] TMC_OFS_MODE     = 8'h14;
  localparam logic [7:0] TMC_OFS_CLKCTL   = 8'h18;
  localparam logic [7:0] TMC_OFS_IRQ_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // timer control register fields
  // ----------------------------------------------------------------
  localparam int TMC_CTL_TF1 = 7;
  localparam int TMC_CTL_TR1 = 6;
  localparam int TMC_CTL_TF0 = 5;
  localparam int TMC_CTL_TR0 = 4;

  // ----------------------------------------------------------------
  // mode register fields: timer 1 in bits 7:4, timer 0 in bits 3:0
  // ----------------------------------------------------------------
  localparam int TMC_MODE_T1_BASE = 4;
  localparam int TMC_MODE_GATE    = 3;
  localparam int TMC_MODE_CT      = 2;
  localparam int TMC_MODE_M1      = 1;
  localparam int TMC_MODE_M0      = 0;

  // clock control: bit 3 picks divide-by-one for timer 0, bit 4 for timer 1
  localparam int TMC_CKC_T0M = 3;
  localparam int TMC_CKC_T1M = 4;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_RST_BYTE = 8'h00;
  localparam logic [1:0] TMC_RST_MASK = 2'h0;
  localparam int         TMC_DIV_SLOW = 12;
  localparam logic [3:0] TMC_DIV_LAST = 4'(TMC_DIV_SLOW - 1);
  localparam int         TMC_MODE0_BITS = 13;

  typedef enum logic [1:0]
  {
    TMC_MODE_13BIT = 2'h0,
    TMC_MODE_16BIT = 2'h1,
    TMC_MODE_8RELD = 2'h2,
    TMC_MODE_SPLIT = 2'h3
  } tmc_mode_e;

endpackage

/* File: verilog/tmc_top.sv */
// tmc_top: two mode-0 counter/timers behind an apb slave, with pin
// synchronisers, shared tick divider and one level interrupt.
// assumes pins are asynchronous to pclk; pclk at 250 MHz.
//
// Contract
// RL1 - timer mode increments once per tick
// RL2 - tick is sysclk divided by one or twelve
// RL3 - counter mode counts falling count-pin edges
// RL4 - external events counted up to quarter clock
// RL5 - source holds each level two clocks
// RL6 - 16-bit count as low and high bytes
// RL7 - two-bit mode field per timer, independent
// RL8 - mode 0: high byte plus low five bits
// RL9 - software masks low byte upper three bits
// RL10 - wrap to zero sets overflow, interrupt
// RL11 - select bit picks ticks or pin edges
// RL12 - run and (gate off or gate pin high)
// RL13 - timer 1 identical with its own bits
// RL14 - setting run leaves count untouched
// RL15 - pins synchronised, edges from consecutive samples
// RL16 - byte write beats same-cycle increment
`timescale 1ns/10ps
module tmc_top
  import tmc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input_0,
  input  wire logic        count_input_1,
  input  wire logic        external_gate_input_0,
  input  wire logic        external_gate_input_1,
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0]  sync_a;   // first stage, read only by sync_b
    logic [1:0]  sync_b;
    logic [1:0]  gsync_a;
    logic [1:0]  gsync_b;
    logic [3:0]  div;
    logic        tick12;
    logic [7:0]  control;
    logic [7:0]  mode;
    logic [7:0]  clkctl;
    logic [1:0]  mask;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
  } tmc_top_s;

  tmc_top_s s_q;
  tmc_top_s s_d;

  tmc_cnt_if t0_if ();
  tmc_cnt_if t1_if ();

  logic access;
  logic wr;
  logic hit;
  logic [7:0] wb;
  logic [1:0] flags;

  // ----------------------------------------------------------------
  // the two timer cores
  // ----------------------------------------------------------------
  tmc_core u_t0
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick12     (s_q.tick12),
    .cnt_pin_s  (s_q.sync_b[0]),
    .gate_pin_s (s_q.gsync_b[0]),
    .cif        (t0_if.core)
  );

  tmc_core u_t1                                               // [RL13]
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick12     (s_q.tick12),
    .cnt_pin_s  (s_q.sync_b[1]),
    .gate_pin_s (s_q.gsync_b[1]),
    .cif        (t1_if.core)
  );

  assign access = psel && penable && !s_q.ready;
  assign wr     = access && pwrite;
  assign wb     = pwdata[7:0];

  assign t0_if.run     = s_q.control[TMC_CTL_TR0];
  assign t0_if.gate_en = s_q.mode[TMC_MODE_GATE];
  assign t0_if.ext_sel = s_q.mode[TMC_MODE_CT];
  assign t0_if.mode    = s_q.mode[TMC_MODE_M1:TMC_MODE_M0];  // [RL7]
  assign t0_if.div1    = s_q.clkctl[TMC_CKC_T0M];
  assign t0_if.wr_low  = wr && paddr == TMC_OFS_T0_LOW;      // [RL6]
  assign t0_if.wr_high = wr && paddr == TMC_OFS_T0_HIGH;
  assign t0_if.wdata   = wb;

  assign t1_if.run     = s_q.control[TMC_CTL_TR1];
  assign t1_if.gate_en = s_q.mode[TMC_MODE_T1_BASE + TMC_MODE_GATE];
  assign t1_if.ext_sel = s_q.mode[TMC_MODE_T1_BASE + TMC_MODE_CT];
  assign t1_if.mode    = s_q.mode[TMC_MODE_T1_BASE + TMC_MODE_M1 -: 2];
  assign t1_if.div1    = s_q.clkctl[TMC_CKC_T1M];
  assign t1_if.wr_low  = wr && paddr == TMC_OFS_T1_LOW;
  assign t1_if.wr_high = wr && paddr == TMC_OFS_T1_HIGH;
  assign t1_if.wdata   = wb;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // two-stage synchronisers; pins must hold two clocks to be seen
    s_d.sync_a  = {count_input_1, count_input_0};            // [RL15] [RL5]
    s_d.sync_b  = s_q.sync_a;
    s_d.gsync_a = {external_gate_input_1, external_gate_input_0};
    s_d.gsync_b = s_q.gsync_a;
    // shared divide-by-twelve tick enable
    s_d.tick12 = (s_q.div == TMC_DIV_LAST);                  // [RL2]
    s_d.div = s_d.tick12 ? 4'h0 : 4'(s_q.div + 4'h1);

    hit = 1'b1;
    s_d.ready = access;
    s_d.slverr = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (access)
    begin
      unique case (paddr)
        TMC_OFS_T0_LOW:   s_d.rdata[7:0] = t0_if.low_byte;   // [RL9]
        TMC_OFS_T0_HIGH:  s_d.rdata[7:0] = t0_if.high_byte;
        TMC_OFS_T1_LOW:   s_d.rdata[7:0] = t1_if.low_byte;
        TMC_OFS_T1_HIGH:  s_d.rdata[7:0] = t1_if.high_byte;
        TMC_OFS_CONTROL:  s_d.rdata[7:0] = s_q.control;
        TMC_OFS_MODE:     s_d.rdata[7:0] = s_q.mode;
        TMC_OFS_CLKCTL:   s_d.rdata[7:0] = s_q.clkctl;
        TMC_OFS_IRQ_MASK: s_d.rdata[1:0] = s_q.mask;
        default:          hit = 1'b0;
      endcase
      s_d.slverr = !hit;
      if (pwrite)
      begin
        s_d.rdata = 32'h0000_0000;
        if (paddr == TMC_OFS_CONTROL)
        begin
          // run bits written directly; overflow flags are write-one-to-clear
          s_d.control[TMC_CTL_TR0] = wb[TMC_CTL_TR0];
          s_d.control[TMC_CTL_TR1] = wb[TMC_CTL_TR1];
          if (wb[TMC_CTL_TF0])
            s_d.control[TMC_CTL_TF0] = 1'b0;
          if (wb[TMC_CTL_TF1])
            s_d.control[TMC_CTL_TF1] = 1'b0;
        end
        if (paddr == TMC_OFS_MODE)
          s_d.mode = wb;
        if (paddr == TMC_OFS_CLKCTL)
          s_d.clkctl = wb;
        if (paddr == TMC_OFS_IRQ_MASK)
          s_d.mask = wb[1:0];
      end
    end
    // a hardware overflow beats a same-cycle clear
    if (t0_if.ovf)                                            // [RL10]
      s_d.control[TMC_CTL_TF0] = 1'b1;
    if (t1_if.ovf)
      s_d.control[TMC_CTL_TF1] = 1'b1;
    flags = {s_d.control[TMC_CTL_TF1], s_d.control[TMC_CTL_TF0]};
    s_d.irq = |(flags & s_d.mask);                            // [RL10]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q         <= '0;
      s_q.control <= TMC_RST_BYTE;
      s_q.mode    <= TMC_RST_BYTE;
      s_q.clkctl  <= TMC_RST_BYTE;
      s_q.mask    <= TMC_RST_MASK;
    end
    else
      s_q <= s_d;
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.slverr;
  assign irq     = s_q.irq;

endmodule
